// ### rtl/mmav_top.sv
`timescale 1ns/1ps
// Behaviour
// [R1] One 16 MB space is decoded for CPU, debug, trigger unit and ADCs.
// [R2] Per-resource arbiters serve accesses to different resources together.
// [R3] A violation is either an illegal access or an uncorrectable ECC error.
// [R4] Unmapped accesses and stores into nonvolatile memory are illegal.
// [R5] CPU illegal access or CPU ECC error raises a machine exception.
// [R6] Trigger unit or ADC illegal access raises that module's error interrupt.
// [R7] An illegal opcode prefetch raises the exception even if never executed.
// [R8] ECC error on CPU, ADC or trigger unit access raises machine exception.
// [R9] Debug ECC errors set write fault or read invalid, never an exception.
// [R10] The CPU program counter is logged into three byte registers.
// [R11] The logged counter is meaningless while the error code is clear.
// [R12] Only the first violation is logged until software clears the code.
module mmav_top (
	input wire logic clk_i, // System bus clock
	input wire logic rst_i, // Synchronous reset, high
	input mmav_pkg::mmav_req_t [3:0] req_i, // Requests by requester
	input wire logic [23:0] cpu_pc_i, // CPU program counter
	input wire logic [2:0] ecc_err_i, // Uncorrectable ECC per resource
	output logic [3:0] gnt_o, // Access served or refused as illegal, pulse
	output logic [3:0] err_o, // Access refused as illegal, pulse
	output logic [2:0] res_sel_o, // Resource access strobe
	output logic [2:0] res_we_o, // Resource write
	output logic [2:0][1:0] res_owner_o, // Requester owning resource
	output logic [2:0][23:0] res_addr_o, // Resource address
	output logic mach_exc_o, // Machine exception to CPU, pulse
	output logic ptu_err_irq_o, // Trigger unit error interrupt, pulse
	output logic adc_err_irq_o, // ADC error interrupt, pulse
	output logic dbg_ram_write_fault_o, // Debug write fault, pulse
	output logic dbg_read_invalid_o, // Debug read invalid, pulse
	output logic irq_o, // Level interrupt
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte select
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o // Wishbone acknowledge
);
	localparam int NREQ = mmav_pkg::NREQ;
	localparam int NRES = mmav_pkg::NRES;

	mmav_pkg::mmav_res_t dec_res [NREQ];
	logic [3:0] dec_ill, gnt_r, err_r, fresh, ill_new, won, ecc_req;
	logic [2:0] sel_r, we_r, sel_nxt, we_nxt, ecc_own;
	logic [2:0][1:0] owner_r, owner_nxt;
	logic [2:0][23:0] addr_r, addr_nxt;
	logic [3:0] cand [NRES];
	logic [3:0] win [NRES];

	// ---------------------------------------------------------------
	// Address decode, one decoder per requester
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NREQ; gi++) begin : g_dec
			mmav_decode u_dec (
				.req_i(req_i[gi]),
				.res_o(dec_res[gi]),
				.ill_o(dec_ill[gi])
			);
			// A request is new until its grant shows
			assign fresh[gi] = req_i[gi].valid && !gnt_r[gi];
			assign ill_new[gi] = fresh[gi] && dec_ill[gi]; // [R4]
		end
	endgenerate

	// ---------------------------------------------------------------
	// Per-resource arbiters
	// ---------------------------------------------------------------
	// Lowest requester index wins; independent arbiters let two masters
	// hit different resources in the same cycle
	genvar gr;
	generate
		for (gr = 0; gr < NRES; gr++) begin : g_arb
			always_comb begin
				cand[gr] = 4'h0;
				for (int i = 0; i < NREQ; i++) begin
					cand[gr][i] = fresh[i] && !dec_ill[i] &&
						(dec_res[i] == mmav_pkg::mmav_res_t'(gr));
				end
			end
			assign win[gr] = cand[gr] & (~cand[gr] + 4'h1); // [R2]
			assign sel_nxt[gr] = |cand[gr]; // [R2]
			assign owner_nxt[gr] = win[gr][1] ? mmav_pkg::REQ_BDC :
				win[gr][2] ? mmav_pkg::REQ_PTU :
				win[gr][3] ? mmav_pkg::REQ_ADC : mmav_pkg::REQ_CPU;
			assign we_nxt[gr] = req_i[owner_nxt[gr]].we;
			assign addr_nxt[gr] = req_i[owner_nxt[gr]].addr;
			// ECC report lands in the cycle the resource is strobed
			assign ecc_own[gr] = ecc_err_i[gr] && sel_r[gr];
		end
	endgenerate
	assign won = win[0] | win[1] | win[2];

	// Attribute resource ECC errors back to their requester
	always_comb begin
		ecc_req = 4'h0;
		for (int r = 0; r < NRES; r++) begin
			if (ecc_own[r]) begin
				ecc_req[owner_r[r]] = 1'b1;
			end
		end
	end

	// Grant and resource strobes, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gnt_r <= 4'h0;
			err_r <= 4'h0;
			sel_r <= 3'h0;
		end else begin
			gnt_r <= won | ill_new;
			err_r <= ill_new;
			sel_r <= sel_nxt;
		end
	end

	// Resource routing carries no control meaning without sel_r
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			we_r <= '0;
			owner_r <= '0;
			addr_r <= '0;
		end else begin
			we_r <= we_nxt;
			owner_r <= owner_nxt;
			addr_r <= addr_nxt; // [R1]
		end
	end

	// ---------------------------------------------------------------
	// Violation responses
	// ---------------------------------------------------------------
	logic exc_nxt, exc_r, ptu_r, adc_r, wf_r, ri_r, bdc_we;
	logic [1:0] bdc_res;

	// Debug accesses never raise the exception
	assign exc_nxt = ill_new[mmav_pkg::REQ_CPU] || // [R5] [R7]
		ecc_req[mmav_pkg::REQ_CPU] || ecc_req[mmav_pkg::REQ_PTU] || // [R8]
		ecc_req[mmav_pkg::REQ_ADC]; // [R8]
	assign bdc_res = (ecc_own[1] && owner_r[1] == mmav_pkg::REQ_BDC) ? 2'h1 :
		(ecc_own[2] && owner_r[2] == mmav_pkg::REQ_BDC) ? 2'h2 : 2'h0;
	assign bdc_we = we_r[bdc_res];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exc_r <= 1'b0;
			ptu_r <= 1'b0;
			adc_r <= 1'b0;
			wf_r <= 1'b0;
			ri_r <= 1'b0;
		end else begin
			exc_r <= exc_nxt; // [R5] [R8]
			ptu_r <= ill_new[mmav_pkg::REQ_PTU]; // [R6]
			adc_r <= ill_new[mmav_pkg::REQ_ADC]; // [R6]
			wf_r <= ecc_req[mmav_pkg::REQ_BDC] && bdc_we; // [R9]
			ri_r <= ecc_req[mmav_pkg::REQ_BDC] && !bdc_we; // [R9]
		end
	end

	// ---------------------------------------------------------------
	// Violation log
	// ---------------------------------------------------------------
	mmav_pkg::mmav_code_t code_r, code_nxt;
	logic [23:0] pc_r;
	logic log_ev, code_clr;
	logic [1:0] src;

	// Source priority: CPU illegal first, then ECC by requester index
	assign src = ill_new[0] || ecc_req[0] ? mmav_pkg::REQ_CPU :
		ecc_req[2] ? mmav_pkg::REQ_PTU : mmav_pkg::REQ_ADC;
	assign code_nxt.ill = ill_new[0]; // [R3]
	assign code_nxt.ecc = !ill_new[0]; // [R3]
	assign code_nxt.src = src;
	assign code_nxt.we = ill_new[0] ? req_i[0].we : 1'b0;
	assign code_nxt.fetch = ill_new[0] ? req_i[0].fetch : 1'b0;
	// Only a clear code, or one cleared in the same cycle, accepts a new entry
	assign log_ev = exc_nxt && (code_r == mmav_pkg::CODE_RST); // [R12]

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_r <= mmav_pkg::CODE_RST;
		end else if (log_ev || (exc_nxt && code_clr)) begin
			code_r <= code_nxt; // [R12]
		end else if (code_clr) begin
			code_r <= mmav_pkg::CODE_RST;
		end
	end

	// PC is left stale on clear: it is only valid while a code is held
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_r <= 24'h000000;
		end else if (log_ev || (exc_nxt && code_clr)) begin
			pc_r <= cpu_pc_i; // [R10] [R11]
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status, enable and clear
	// ---------------------------------------------------------------
	logic [3:0] ist_r;
	logic [3:0] ien_r;
	logic [3:0] ev;
	logic [3:0] iclr;
	logic irq_r;

	assign ev = {ecc_req[mmav_pkg::REQ_BDC], ill_new[mmav_pkg::REQ_ADC],
		ill_new[mmav_pkg::REQ_PTU], exc_nxt};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_r <= 4'h0;
			irq_r <= 1'b0;
		end else begin
			ist_r <= (ist_r & ~iclr) | ev;
			irq_r <= |(((ist_r & ~iclr) | ev) & ien_r);
		end
	end

	// ---------------------------------------------------------------
	// Wishbone slave
	// ---------------------------------------------------------------
	logic ack_r;
	logic [31:0] dat_r;
	logic wb_go;
	logic wr_go;
	logic [31:0] rd_mux;

	// Answer one cycle after the strobe, drop ack the cycle after
	assign wb_go = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_go = wb_go && wb_we_i && wb_sel_i[0];
	assign code_clr = wr_go && (wb_adr_i == mmav_pkg::REG_CODE);
	assign iclr = (wr_go && (wb_adr_i == mmav_pkg::REG_ICLR)) ?
		wb_dat_i[3:0] : 4'h0;
	// Unmapped addresses read zero and are still acknowledged
	assign rd_mux = (wb_adr_i == mmav_pkg::REG_CODE) ? {26'h0, code_r} :
		(wb_adr_i == mmav_pkg::REG_PCH) ? {24'h0, pc_r[23:16]} :
		(wb_adr_i == mmav_pkg::REG_PCM) ? {24'h0, pc_r[15:8]} :
		(wb_adr_i == mmav_pkg::REG_PCL) ? {24'h0, pc_r[7:0]} :
		(wb_adr_i == mmav_pkg::REG_ISTAT) ? {28'h0, ist_r} :
		(wb_adr_i == mmav_pkg::REG_IEN) ? {28'h0, ien_r} : 32'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
			ien_r <= mmav_pkg::IEN_RST;
		end else begin
			ack_r <= wb_go;
			dat_r <= wb_go && !wb_we_i ? rd_mux : 32'h0;
			if (wr_go && (wb_adr_i == mmav_pkg::REG_IEN)) begin
				ien_r <= wb_dat_i[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign gnt_o = gnt_r;
	assign err_o = err_r;
	assign res_sel_o = sel_r;
	assign res_we_o = we_r;
	assign res_owner_o = owner_r;
	assign res_addr_o = addr_r;
	assign mach_exc_o = exc_r;
	assign ptu_err_irq_o = ptu_r;
	assign adc_err_irq_o = adc_r;
	assign dbg_ram_write_fault_o = wf_r;
	assign dbg_read_invalid_o = ri_r;
	assign irq_o = irq_r;
	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_nvm_store;
		req_i[1].valid && req_i[1].we && req_i[1].addr >= mmav_pkg::FL_LO
			|-> dec_ill[1];
	endproperty
	a_nvm_store: assert property (p_nvm_store) // [R4]
		else $error("store to flash not illegal");

	property p_cpu_ill;
		ill_new[0] |=> mach_exc_o && err_o[0] && gnt_o[0];
	endproperty
	a_cpu_ill: assert property (p_cpu_ill) // [R5]
		else $error("CPU illegal access without exception");

	property p_ptu_ill;
		ill_new[2] |=> ptu_err_irq_o ##1 !ptu_err_irq_o || ill_new[2];
	endproperty
	a_ptu_ill: assert property (p_ptu_ill) // [R6]
		else $error("trigger unit error interrupt missing");

	property p_fetch;
		fresh[0] && req_i[0].fetch && req_i[0].addr <= mmav_pkg::PER_HI
			|=> mach_exc_o;
	endproperty
	a_fetch: assert property (p_fetch) // [R7]
		else $error("illegal prefetch without exception");

	property p_parallel;
		fresh[0] && fresh[1] && !dec_ill[0] && !dec_ill[1] &&
			dec_res[0] != dec_res[1] |=> gnt_o[0] && gnt_o[1];
	endproperty
	a_parallel: assert property (p_parallel) // [R2]
		else $error("accesses to different resources not parallel");

	property p_ecc_exc;
		ecc_own[0] && owner_r[0] != mmav_pkg::REQ_BDC |=> mach_exc_o;
	endproperty
	a_ecc_exc: assert property (p_ecc_exc) // [R8]
		else $error("ECC error without exception");

	property p_bdc_ecc;
		ecc_req[1] && exc_nxt == 1'b0
			|=> (dbg_ram_write_fault_o ^ dbg_read_invalid_o) && !mach_exc_o;
	endproperty
	a_bdc_ecc: assert property (p_bdc_ecc) // [R9]
		else $error("debug ECC error handled wrongly");

	property p_log_pc;
		log_ev |=> pc_r == $past(cpu_pc_i) && code_r != mmav_pkg::CODE_RST;
	endproperty
	a_log_pc: assert property (p_log_pc) // [R10]
		else $error("program counter not logged");

	property p_first_only;
		code_r != mmav_pkg::CODE_RST && !code_clr |=> $stable(pc_r) &&
			$stable(code_r);
	endproperty
	a_first_only: assert property (p_first_only) // [R12]
		else $error("log overwritten before clear");

	property p_cause;
		code_r != mmav_pkg::CODE_RST |-> code_r.ill ^ code_r.ecc;
	endproperty
	a_cause: assert property (p_cause) // [R3]
		else $error("logged cause is neither illegal nor ECC");

	property p_wb_ack;
		wb_go |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack)
		else $error("wishbone ack timing wrong");

	c_parallel: cover property (gnt_o[0] && gnt_o[1] && !err_o[0]);
	c_exc: cover property (mach_exc_o ##1 wb_ack_o);
	c_bdc_ecc: cover property (dbg_read_invalid_o);
	c_irq: cover property (irq_o);

endmodule // mmav_top

// ### rtl/mmav_pkg.sv
package mmav_pkg;

	// ---------------------------------------------------------------
	// Address space and requesters
	// ---------------------------------------------------------------
	localparam int AW = 24;
	localparam int NREQ = 4;
	localparam int NRES = 3;
	localparam logic [1:0] REQ_CPU = 2'h0;
	localparam logic [1:0] REQ_BDC = 2'h1;
	localparam logic [1:0] REQ_PTU = 2'h2;
	localparam logic [1:0] REQ_ADC = 2'h3;

	// Resource targets; the value is the index of the resource strobe
	typedef enum logic [1:0] {
		RES_NVM = 2'h0,
		RES_RAM = 2'h1,
		RES_PER = 2'h2,
		RES_NONE = 2'h3
	} mmav_res_t;

	// ---------------------------------------------------------------
	// Global memory map
	// ---------------------------------------------------------------
	localparam logic [23:0] PER_LO = 24'h000000;
	localparam logic [23:0] PER_HI = 24'h000FFF;
	localparam logic [23:0] RAM_LO = 24'h001000;
	localparam logic [23:0] RAM_HI = 24'h001FFF;
	localparam logic [23:0] EE_LO = 24'h100000;
	localparam logic [23:0] EE_HI = 24'h1001FF;
	localparam logic [23:0] FL_LO = 24'hFF8000;
	localparam logic [23:0] FL_HI = 24'hFFFFFF;

	// One request from a requester, held until granted
	typedef struct packed {
		logic valid;
		logic we;
		logic fetch;
		logic [23:0] addr;
	} mmav_req_t;

	// Logged cause of the first access violation
	typedef struct packed {
		logic fetch;
		logic we;
		logic [1:0] src;
		logic ecc;
		logic ill;
	} mmav_code_t;
	localparam mmav_code_t CODE_RST = 6'h00;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses) and interrupt bits
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CODE = 8'h00;
	localparam logic [7:0] REG_PCH = 8'h04;
	localparam logic [7:0] REG_PCM = 8'h08;
	localparam logic [7:0] REG_PCL = 8'h0C;
	localparam logic [7:0] REG_ISTAT = 8'h10;
	localparam logic [7:0] REG_ICLR = 8'h14;
	localparam logic [7:0] REG_IEN = 8'h18;
	localparam int IRQ_W = 4;
	localparam int IRQ_EXC = 0;
	localparam int IRQ_PTU = 1;
	localparam int IRQ_ADC = 2;
	localparam int IRQ_BDC = 3;
	localparam logic [3:0] IEN_RST = 4'h0;

endpackage

// ### rtl/mmav_decode.sv
`timescale 1ns/1ps
// Classifies one request against the global map; purely combinational
module mmav_decode (
	input mmav_pkg::mmav_req_t req_i, // Request under test
	output mmav_pkg::mmav_res_t res_o, // Target resource
	output logic ill_o // Access is illegal
);
	logic in_per;
	logic in_ram;
	logic in_nvm;
	logic [23:0] a;

	// ---------------------------------------------------------------
	// Region decode
	// ---------------------------------------------------------------
	// Full 24-bit compare: the whole 16 MB space is decoded
	assign a = req_i.addr;
	assign in_per = (a >= mmav_pkg::PER_LO) && (a <= mmav_pkg::PER_HI);
	assign in_ram = (a >= mmav_pkg::RAM_LO) && (a <= mmav_pkg::RAM_HI);
	assign in_nvm = ((a >= mmav_pkg::EE_LO) && (a <= mmav_pkg::EE_HI)) ||
		((a >= mmav_pkg::FL_LO) && (a <= mmav_pkg::FL_HI));

	// Unmapped, store to NONVOLATILE_MEMORY or fetch from peripherals is illegal
	assign ill_o = !(in_per || in_ram || in_nvm) || // [R4]
		(req_i.we && in_nvm) || // [R4]
		(req_i.fetch && in_per); // [R7]
	assign res_o = in_nvm ? mmav_pkg::RES_NVM :
		in_ram ? mmav_pkg::RES_RAM :
		in_per ? mmav_pkg::RES_PER : mmav_pkg::RES_NONE;

endmodule // mmav_decode

// ### bench/mmav_req_model.sv
`timescale 1ns/1ps
// Requesters and memories on the far side of the block
module mmav_req_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, high
	input wire logic [3:0] go_i, // Load a new request
	input mmav_pkg::mmav_req_t [3:0] cmd_i, // Request to load
	input wire logic [3:0] gnt_i, // Grant from the block
	input wire logic [2:0] sel_i, // Resource strobes
	input wire logic [2:0] ecc_arm_i, // Corrupt accesses to resource
	output mmav_pkg::mmav_req_t [3:0] req_o, // Held requests
	output logic [2:0] ecc_err_o // Uncorrectable error flags
);
	mmav_pkg::mmav_req_t [3:0] req_r;

	// Memories flag the error only in the strobe cycle
	assign req_o = req_r;
	assign ecc_err_o = sel_i & ecc_arm_i;

	// Hold until granted; released address lines do not keep old values
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 4; k++) begin
			if (rst_i) begin
				req_r[k] <= '0;
			end else if (go_i[k]) begin
				req_r[k] <= cmd_i[k];
			end else if (gnt_i[k]) begin
				req_r[k].valid <= 1'b0;
				req_r[k].addr <= ~req_r[k].addr;
			end
		end
	end
endmodule // mmav_req_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// Row: requester, request, target (3 is none), outcomes
	typedef struct packed {
		logic [1:0] k;
		logic we;
		logic fetch;
		logic [23:0] addr;
		logic ecc;
		logic [1:0] r;
		logic [3:0] e1;
		logic [2:0] e2;
	} mmav_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cs = 1'b0;
	logic we = 1'b0;
	logic [3:0] bsel = 4'hF;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] rdat;
	logic ack;
	logic [23:0] cpu_pc = 24'h000000;
	logic [2:0] ecc_arm = 3'h0;
	logic [2:0] ecc_err;
	logic [3:0] go = 4'h0;
	mmav_pkg::mmav_req_t [3:0] cmd = '0;
	mmav_pkg::mmav_req_t [3:0] req;
	logic [3:0] gnt;
	logic [3:0] err;
	logic [2:0] sel;
	logic [2:0] rwe;
	logic [2:0][1:0] owner;
	logic [2:0][23:0] raddr;
	logic exc;
	logic ptu_irq;
	logic adc_irq;
	logic wf;
	logic ri;
	logic irq;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	mmav_row_t rows [16];
	mmav_row_t rw;
	logic [31:0] q;
	logic [3:0] g;
	logic [6:0] o1;
	logic [2:0] o2;
	logic [2:0][1:0] own_c;
	logic [2:0][23:0] adr_c;
	logic [2:0] we_c;
	logic [5:0] code;
	logic [3:0] gq [$];
	logic [7:0] offs [6];

	// 10 MHz clock and a hang limit well beyond the run length
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			chk(32'h0, 32'h1, "timeout");
			close_out();
		end
	end

	mmav_top mmav_top_inst (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
		.cpu_pc_i(cpu_pc), .ecc_err_i(ecc_err), .gnt_o(gnt), .err_o(err),
		.res_sel_o(sel), .res_we_o(rwe), .res_owner_o(owner),
		.res_addr_o(raddr), .mach_exc_o(exc), .ptu_err_irq_o(ptu_irq),
		.adc_err_irq_o(adc_irq), .dbg_ram_write_fault_o(wf),
		.dbg_read_invalid_o(ri), .irq_o(irq), .wb_cyc_i(cs), .wb_stb_i(cs),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(bsel),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	mmav_req_model mmav_req_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.go_i(go), .cmd_i(cmd), .gnt_i(gnt), .sel_i(sel),
		.ecc_arm_i(ecc_arm), .req_o(req), .ecc_err_o(ecc_err));

	task close_out;
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask

	// Classic cycle: hold everything until ack is sampled, then idle a cycle
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cs <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 30);
		q = rdat;
		chk(32'(ack), 32'h1, "bus ack");
		cs <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
		wb(a, 1'b0, 32'h0);
		chk(q, e, m);
	endtask

	// Launch requests, capture the grant cycle and the cycle after it
	task access(input logic [3:0] m);
		int n;
		n = 0;
		go <= m;
		@(posedge clk_i);
		go <= 4'h0;
		do begin
			@(posedge clk_i);
			n++;
		end while (gnt === 4'h0 && n < 30);
		g = gnt;
		o1 = {|err, exc, ptu_irq, adc_irq, sel};
		own_c = owner;
		adr_c = raddr;
		we_c = rwe;
		@(posedge clk_i);
		o2 = {exc, wf, ri};
	endtask

	initial begin
		offs = '{mmav_pkg::REG_CODE, mmav_pkg::REG_PCH, mmav_pkg::REG_PCM,
			mmav_pkg::REG_PCL, mmav_pkg::REG_ISTAT, mmav_pkg::REG_IEN};
		rows = '{'{2'h0, 1'h0, 1'h0, 24'h001000, 1'h0, 2'h1, 4'h0, 3'h0},
			'{2'h0, 1'h1, 1'h0, 24'h001FFE, 1'h0, 2'h1, 4'h0, 3'h0},
			'{2'h0, 1'h0, 1'h1, 24'hFFFFF8, 1'h0, 2'h0, 4'h0, 3'h0},
			'{2'h0, 1'h0, 1'h0, 24'h000010, 1'h0, 2'h2, 4'h0, 3'h0},
			'{2'h0, 1'h1, 1'h0, 24'h100000, 1'h0, 2'h3, 4'hC, 3'h0},
			'{2'h0, 1'h0, 1'h0, 24'h200000, 1'h0, 2'h3, 4'hC, 3'h0},
			'{2'h0, 1'h0, 1'h1, 24'h000020, 1'h0, 2'h3, 4'hC, 3'h0},
			'{2'h0, 1'h0, 1'h0, 24'h001100, 1'h1, 2'h1, 4'h0, 3'h4},
			'{2'h2, 1'h1, 1'h0, 24'h300000, 1'h0, 2'h3, 4'hA, 3'h0},
			'{2'h3, 1'h0, 1'h0, 24'h0FFFFF, 1'h0, 2'h3, 4'h9, 3'h0},
			'{2'h2, 1'h0, 1'h0, 24'hFF8000, 1'h1, 2'h0, 4'h0, 3'h4},
			'{2'h3, 1'h0, 1'h0, 24'h001010, 1'h1, 2'h1, 4'h0, 3'h4},
			'{2'h1, 1'h1, 1'h0, 24'h001020, 1'h1, 2'h1, 4'h0, 3'h2},
			'{2'h1, 1'h0, 1'h0, 24'hFF9000, 1'h1, 2'h0, 4'h0, 3'h1},
			'{2'h1, 1'h1, 1'h0, 24'hFFC000, 1'h0, 2'h3, 4'h8, 3'h0},
			'{2'h3, 1'h1, 1'h0, 24'h000100, 1'h0, 2'h2, 4'h0, 3'h0}};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (offs[j]) rd_chk(offs[j], 32'h0, "reset value");
		wb(8'hFC, 1'b1, 32'h000000FF);
		rd_chk(8'hFC, 32'h0, "unmapped");
		wb(mmav_pkg::REG_PCM, 1'b1, 32'h000000FF);
		rd_chk(mmav_pkg::REG_PCM, 32'h0, "read-only pc");
		// Single accesses, one per row, log cleared after each
		for (int i = 0; i < 16; i++) begin
			rw = rows[i];
			cmd[rw.k] <= {1'b1, rw.we, rw.fetch, rw.addr};
			ecc_arm <= rw.ecc ? 3'h1 << rw.r : 3'h0;
			cpu_pc <= {i[7:0], 8'h5A, 8'hC3};
			access(4'h1 << rw.k);
			chk(32'(g), 32'(4'h1 << rw.k), "grant");
			chk(32'(o1), 32'({rw.e1, rw.r == 2'h3 ? 3'h0 : 3'h1 << rw.r}),
				"outcome");
			chk(32'(o2), 32'(rw.e2), "late outcome");
			if (rw.r != 2'h3) begin
				chk(32'(own_c[rw.r]), 32'(rw.k), "owner");
				chk(32'(adr_c[rw.r]), 32'(rw.addr), "address");
				chk(32'(we_c[rw.r]), 32'(rw.we), "write");
			end
			rd_chk(mmav_pkg::REG_ISTAT, 32'({|rw.e2[1:0], rw.e1[0], rw.e1[1],
				rw.e1[2] | rw.e2[2]}), "status");
			code = (rw.e1[2] | rw.e2[2]) ?
				{rw.fetch, rw.we, rw.k, rw.ecc, rw.e1[3]} : 6'h00;
			rd_chk(mmav_pkg::REG_CODE, 32'(code), "code");
			if (code != 6'h00) begin
				rd_chk(mmav_pkg::REG_PCH, 32'(i), "pc high");
				rd_chk(mmav_pkg::REG_PCM, 32'h5A, "pc mid");
				rd_chk(mmav_pkg::REG_PCL, 32'hC3, "pc low");
			end
			wb(mmav_pkg::REG_CODE, 1'b1, 32'h0);
			wb(mmav_pkg::REG_ICLR, 1'b1, 32'h0000000F);
		end
		// Second violation must not overwrite the first log
		ecc_arm <= 3'h0;
		cmd[0] <= {1'b1, 1'b0, 1'b0, 24'h200000};
		cpu_pc <= 24'h123456;
		access(4'h1);
		cmd[0] <= {1'b1, 1'b1, 1'b0, 24'hFF8000};
		cpu_pc <= 24'h654321;
		access(4'h1);
		rd_chk(mmav_pkg::REG_CODE, 32'h01, "first code kept");
		rd_chk(mmav_pkg::REG_PCL, 32'h56, "first pc kept");
		wb(mmav_pkg::REG_CODE, 1'b1, 32'h0);
		rd_chk(mmav_pkg::REG_CODE, 32'h0, "code cleared");
		// Both violations left the exception status bit set
		wb(mmav_pkg::REG_ICLR, 1'b1, 32'h0000000F);
		// Different resources in parallel, then a contended resource
		cmd[0] <= {1'b1, 1'b0, 1'b0, 24'h001000};
		cmd[1] <= {1'b1, 1'b0, 1'b0, 24'hFF8000};
		access(4'h3);
		chk(32'(g), 32'h3, "parallel grant");
		chk(32'(o1[2:0]), 32'h3, "parallel strobes");
		cmd[0] <= {1'b1, 1'b0, 1'b0, 24'h001000};
		cmd[2] <= {1'b1, 1'b0, 1'b0, 24'h001004};
		go <= 4'h5;
		@(posedge clk_i);
		go <= 4'h0;
		repeat (8) begin
			@(posedge clk_i);
			if (gnt !== 4'h0) gq.push_back(gnt);
		end
		chk(32'(gq.size()), 32'h2, "grant count");
		chk(32'(gq[0]), 32'h1, "first grant");
		chk(32'(gq[1]), 32'h4, "second grant");
		// Interrupt: raise, mask, unmask, clear
		wb(mmav_pkg::REG_IEN, 1'b1, 32'h2);
		rd_chk(mmav_pkg::REG_IEN, 32'h2, "enable");
		cmd[2] <= {1'b1, 1'b1, 1'b0, 24'h300000};
		access(4'h4);
		rd_chk(mmav_pkg::REG_ISTAT, 32'h2, "status set");
		chk(32'(irq), 32'h1, "irq set");
		wb(mmav_pkg::REG_IEN, 1'b1, 32'h0);
		@(posedge clk_i);
		chk(32'(irq), 32'h0, "irq masked");
		wb(mmav_pkg::REG_IEN, 1'b1, 32'h2);
		@(posedge clk_i);
		chk(32'(irq), 32'h1, "irq unmasked");
		wb(mmav_pkg::REG_ICLR, 1'b1, 32'h2);
		@(posedge clk_i);
		chk(32'(irq), 32'h0, "irq cleared");
		rd_chk(mmav_pkg::REG_ISTAT, 32'h0, "status cleared");
		// Reset in mid-run with an enabled interrupt pending
		wb(mmav_pkg::REG_IEN, 1'b1, 32'h4);
		cmd[3] <= {1'b1, 1'b0, 1'b0, 24'h300000};
		access(4'h8);
		chk(32'(irq), 32'h1, "irq pending");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(irq), 32'h0, "irq after reset");
		rd_chk(mmav_pkg::REG_IEN, 32'h0, "enable after reset");
		rd_chk(mmav_pkg::REG_ISTAT, 32'h0, "status after reset");
		close_out();
	end
endmodule // tb_top
